// ---- rtl/sdp_ram_secded_ecc.sv ----
// Purpose: 512 x 64 simple dual-port memory with SECDED check bits
// Assumes: One clock; configuration inputs steady or same-domain
// Notes:   Array is 72 bits wide; no reset on the array contents
//
// What this block does
// - 512 by 64 store, eight check bits
// - Encoder computes check bits on every write
// - Decoder corrects single, detects double errors
// - Check bits written at each write edge
// - Encode-only drives check bits from a register loaded on each write
// - All 72 bits decoded; two error flags
// - Corrected data out, array left untouched
// - Output register option delays data and flags
// - Report address of the word being read
// - Error injection exercises correction and detection
// - Standard mode ignores external check bits
// - Decode-only stores user check bits
// - Check-bit output only in encode-only mode
// - Dedicated write port and read port
// - Read data holds until next read
// - Concurrent encode and decode allowed
// - Read-first or write-first collision behaviour
// - Embedded variant: standard mode, address report forced to zero
`include "sdp_ecc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module sdp_ram_secded_ecc
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      encoder_enable,
    input  wire logic                      decoder_enable,
    input  wire logic                      output_register_enable,
    input  wire logic                      write_first_mode,
    input  wire logic                      fifo_variant,
    input  wire logic                      write_enable,
    input  wire sdp_ecc_pkg::bus_addr_type write_address,
    input  wire sdp_ecc_pkg::write_we_type write_byte_we,
    input  wire sdp_ecc_pkg::first_we_type first_port_byte_we,
    input  wire sdp_ecc_pkg::data_type     write_data_in,
    input  wire sdp_ecc_pkg::check_type    write_check_in,
    input  wire logic                      inject_single,
    input  wire logic                      inject_double,
    input  wire logic                      read_enable,
    input  wire sdp_ecc_pkg::bus_addr_type read_address,
    output var  sdp_ecc_pkg::data_type     read_data_out,
    output var  sdp_ecc_pkg::check_type    read_check_out,
    output var  logic                      single_error_flag,
    output var  logic                      double_error_flag,
    output var  sdp_ecc_pkg::waddr_type    read_address_report,
    output var  sdp_ecc_pkg::check_type    check_bits_out
);
    import sdp_ecc_pkg::*;

    // =====================================================
    // Code functions
    // Positions 1..71 of the Hamming word; powers of two hold check bits
    function automatic check_type ham_encode(input data_type d);
        check_type c;
        int        k;
        c = `SDP_CHECK_RST;
        k = 0;
        for (int p = 1; p <= `SDP_CODE_LAST; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                for (int b = 0; b < `SDP_HAM_BITS; b++)
                begin
                    if (((p >> b) & 1) == 1)
                    begin
                        c[b] = c[b] ^ d[k];
                    end
                end
                k++;
            end
        end
        c[`SDP_CHECK_W-1] = (^d) ^ (^c[`SDP_HAM_BITS-1:0]);
        return c;
    endfunction : ham_encode

    // Flip the data bit at Hamming position s, if it is a data position
    function automatic data_type ham_fix(input data_type d, input logic [6:0] s);
        data_type r;
        int       k;
        r = d;
        k = 0;
        for (int p = 1; p <= `SDP_CODE_LAST; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                if (p == int'(s))
                begin
                    r[k] = ~d[k];
                end
                k++;
            end
        end
        return r;
    endfunction : ham_fix

    // =====================================================
    // Effective configuration
    logic eff_enc;
    logic eff_dec;
    logic encode_only;

    assign eff_enc     = encoder_enable | fifo_variant;
    assign eff_dec     = decoder_enable | fifo_variant;
    assign encode_only = eff_enc & ~eff_dec;

    // =====================================================
    // Write port
    word_type  mem [0:`SDP_DEPTH-1];
    waddr_type waddr;
    waddr_type raddr;
    logic      wr_go;
    data_type  wr_mask;
    data_type  wr_data;
    check_type wr_gen;
    check_type wr_check;
    word_type  wr_word;

    assign waddr   = write_address[`SDP_ADDR_MSB:`SDP_ADDR_LSB];
    assign raddr   = read_address[`SDP_ADDR_MSB:`SDP_ADDR_LSB];
    // Write only while the byte enables are strapped as expected
    assign wr_go   = write_enable & (&write_byte_we)
                   & (first_port_byte_we == 4'h0);
    assign wr_gen  = ham_encode(write_data_in);
    // Check bits come from the clean word; the flip lands after
    assign wr_mask = inject_double ? `SDP_INJ_TWO :
                     inject_single ? `SDP_INJ_ONE : `SDP_DATA_RST;
    assign wr_data = write_data_in ^ wr_mask;
    assign wr_check = eff_enc ? wr_gen : write_check_in;
    assign wr_word = {wr_check, wr_data};

    always_ff @(posedge clk)
    begin
        if (wr_go)
        begin
            mem[waddr] <= wr_word;
        end
    end

    // Encoder result toward fabric, encode-only mode only
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            check_bits_out <= `SDP_CHECK_RST;
        end
        else if (wr_go)
        begin
            check_bits_out <= encode_only ? wr_gen : `SDP_CHECK_RST;
        end
    end

    // =====================================================
    // Read port and decoder
    word_type   rd_word;
    data_type   rd_data;
    check_type  rd_check;
    check_type  rd_gen;
    logic [6:0] syndrome;
    logic       overall;
    data_type   dec_data;
    result_type dec_result;

    // Collision: bypass the incoming word when write-first
    assign rd_word  = (write_first_mode & wr_go & (waddr == raddr)) ?
                      wr_word : mem[raddr];
    assign rd_data  = rd_word[`SDP_DATA_W-1:0];
    assign rd_check = rd_word[`SDP_WORD_W-1:`SDP_DATA_W];
    assign rd_gen   = ham_encode(rd_data);
    assign syndrome = rd_gen[`SDP_HAM_BITS-1:0]
                    ^ rd_check[`SDP_HAM_BITS-1:0];
    assign overall  = ^rd_word;

    always_comb
    begin
        dec_data   = rd_data;
        dec_result = RESULT_CLEAN;
        if (eff_dec)
        begin
            if (overall)
            begin
                dec_data   = ham_fix(rd_data, syndrome);
                dec_result = RESULT_SINGLE;
            end
            else if (syndrome != 7'h00)
            begin
                dec_result = RESULT_DOUBLE;
            end
        end
    end

    // =====================================================
    // First read stage, used when the output register is on
    data_type   stage_data_r;
    check_type  stage_check_r;
    result_type stage_result_r;
    waddr_type  stage_addr_r;
    logic       stage_valid_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage_data_r   <= `SDP_DATA_RST;
            stage_check_r  <= `SDP_CHECK_RST;
            stage_result_r <= RESULT_CLEAN;
            stage_addr_r   <= `SDP_WADDR_RST;
        end
        else if (read_enable)
        begin
            stage_data_r   <= dec_data;
            stage_check_r  <= rd_check;
            stage_result_r <= dec_result;
            stage_addr_r   <= raddr;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage_valid_r <= 1'b0;
        end
        else
        begin
            stage_valid_r <= read_enable & output_register_enable;
        end
    end

    // =====================================================
    // Output registers; the array itself is never rewritten
    logic       load_direct;
    logic       load_staged;
    data_type   out_data_nxt;
    check_type  out_check_nxt;
    result_type out_result_nxt;
    waddr_type  out_addr_nxt;

    assign load_direct = read_enable & ~output_register_enable;
    assign load_staged = stage_valid_r & output_register_enable;

    always_comb
    begin
        if (load_staged)
        begin
            out_data_nxt   = stage_data_r;
            out_check_nxt  = stage_check_r;
            out_result_nxt = stage_result_r;
            out_addr_nxt   = stage_addr_r;
        end
        else
        begin
            out_data_nxt   = dec_data;
            out_check_nxt  = rd_check;
            out_result_nxt = dec_result;
            out_addr_nxt   = raddr;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_data_out  <= `SDP_DATA_RST;
            read_check_out <= `SDP_CHECK_RST;
        end
        else if (load_direct | load_staged)
        begin
            read_data_out  <= out_data_nxt;
            read_check_out <= out_check_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            single_error_flag <= 1'b0;
            double_error_flag <= 1'b0;
        end
        else if (load_direct | load_staged)
        begin
            single_error_flag <= (out_result_nxt == RESULT_SINGLE);
            double_error_flag <= (out_result_nxt == RESULT_DOUBLE);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_address_report <= `SDP_WADDR_RST;
        end
        else if (load_direct | load_staged)
        begin
            read_address_report <= fifo_variant ? `SDP_WADDR_RST : out_addr_nxt;
        end
    end

endmodule : sdp_ram_secded_ecc

`default_nettype wire

// ---- rtl/sdp_ecc_defines.svh ----
// Purpose: Constants for the SECDED simple dual-port memory
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef SDP_ECC_DEFINES_SVH
`define SDP_ECC_DEFINES_SVH

// =====================================================
// Geometry
`define SDP_DATA_W      64
`define SDP_CHECK_W     8
`define SDP_WORD_W      72
`define SDP_DEPTH       512
`define SDP_WADDR_W     9
`define SDP_BUS_ADDR_W  16
`define SDP_ADDR_LSB    6
`define SDP_ADDR_MSB    14
`define SDP_HAM_BITS    7
`define SDP_CODE_LAST   71

// =====================================================
// Reset values and injection masks
`define SDP_DATA_RST    64'h0000_0000_0000_0000
`define SDP_CHECK_RST   8'h00
`define SDP_WADDR_RST   9'h000
`define SDP_INJ_ONE     64'h0000_0000_0000_0001
`define SDP_INJ_TWO     64'h0000_0000_0000_0003

`endif

// ---- rtl/sdp_ecc_pkg.sv ----
// Purpose: Types for the SECDED simple dual-port memory
// Assumes: sdp_ecc_defines.svh holds the numbers
// Notes:   Types only
`include "sdp_ecc_defines.svh"

package sdp_ecc_pkg;

    typedef logic [`SDP_DATA_W-1:0]     data_type;
    typedef logic [`SDP_CHECK_W-1:0]    check_type;
    typedef logic [`SDP_WORD_W-1:0]     word_type;
    typedef logic [`SDP_WADDR_W-1:0]    waddr_type;
    typedef logic [`SDP_BUS_ADDR_W-1:0] bus_addr_type;
    typedef logic [3:0]                 first_we_type;
    typedef logic [7:0]                 write_we_type;

    // Read outcome, one-hot
    typedef enum logic [2:0]
    {
        RESULT_CLEAN  = 3'b001,
        RESULT_SINGLE = 3'b010,
        RESULT_DOUBLE = 3'b100
    } result_type;

endpackage : sdp_ecc_pkg

// ---- tb/sdp_ram_secded_ecc_sva.sv ----
// Purpose: Port-level checks of the SECDED memory
// Assumes: Single clock, async active-low reset
// Notes:   Bound to every instance of the memory
`timescale 1ns/1ns
`default_nettype none
module sdp_ecc_chk
(
    input wire logic                      clk,
    input wire logic                      reset_n,
    input wire logic                      encoder_enable,
    input wire logic                      decoder_enable,
    input wire logic                      output_register_enable,
    input wire logic                      fifo_variant,
    input wire logic                      write_enable,
    input wire sdp_ecc_pkg::write_we_type write_byte_we,
    input wire sdp_ecc_pkg::first_we_type first_port_byte_we,
    input wire logic                      read_enable,
    input wire sdp_ecc_pkg::bus_addr_type read_address,
    input wire sdp_ecc_pkg::data_type     read_data_out,
    input wire sdp_ecc_pkg::check_type    read_check_out,
    input wire logic                      single_error_flag,
    input wire logic                      double_error_flag,
    input wire sdp_ecc_pkg::waddr_type    read_address_report,
    input wire sdp_ecc_pkg::check_type    check_bits_out
);
    import sdp_ecc_pkg::*;
    // ====
    // Helpers
    waddr_type ra_w;
    logic      wr_take;
    logic      enc_only;
    assign ra_w     = read_address[14:6];
    assign wr_take  = write_enable && write_byte_we == 8'hff && first_port_byte_we == 4'h0;
    assign enc_only = encoder_enable && !decoder_enable && !fifo_variant;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd_now;
        read_enable && !output_register_enable;
    endsequence
    sequence s_rd_reg;
        read_enable && output_register_enable && !fifo_variant ##1 output_register_enable && !fifo_variant;
    endsequence
    chk_addr_now: assert property (s_rd_now |=> read_address_report == ($past(fifo_variant) ? 9'h000 : $past(ra_w)))
        else $error("read address report wrong");
    chk_addr_reg: assert property (s_rd_reg |=> read_address_report == $past(ra_w, 2))
        else $error("registered address report wrong");
    chk_read_hold: assert property (!read_enable && !output_register_enable |=>
        $stable(read_data_out) && $stable(single_error_flag) && $stable(double_error_flag))
        else $error("read result changed without read");
    chk_check_hold: assert property (!read_enable && !output_register_enable |=>
        $stable(read_check_out) && $stable(read_address_report))
        else $error("read check bits changed without read");
    chk_flags_excl: assert property (!(single_error_flag && double_error_flag))
        else $error("both error flags high");
    chk_flags_off: assert property (s_rd_now ##0 !decoder_enable && !fifo_variant |=>
        !single_error_flag && !double_error_flag)
        else $error("flags raised with decoder off");
    chk_parity_hold: assert property (!wr_take |=> $stable(check_bits_out))
        else $error("check output moved without write");
    chk_parity_zero: assert property (wr_take && !enc_only |=> check_bits_out == 8'h00)
        else $error("check output driven outside encode-only");
endmodule : sdp_ecc_chk
bind sdp_ram_secded_ecc sdp_ecc_chk chk (.*);
`default_nettype wire

// ---- tb/fabric_model.sv ----
// Purpose: Fabric logic on both memory ports
// Assumes: Shares the memory clock
// Notes:   Bench calls op for each transfer
`timescale 1ns/1ns
`default_nettype none
module fabric_model
(
    input  wire logic                      clk,
    output var  logic                      write_enable,
    output var  sdp_ecc_pkg::bus_addr_type write_address,
    output var  sdp_ecc_pkg::write_we_type write_byte_we,
    output var  sdp_ecc_pkg::first_we_type first_port_byte_we,
    output var  sdp_ecc_pkg::data_type     write_data_in,
    output var  sdp_ecc_pkg::check_type    write_check_in,
    output var  logic                      inject_single,
    output var  logic                      inject_double,
    output var  logic                      read_enable,
    output var  sdp_ecc_pkg::bus_addr_type read_address
);
    import sdp_ecc_pkg::*;
    initial
    begin
        {write_enable, read_enable, inject_single, inject_double} = 4'h0;
        {write_address, read_address, write_data_in, write_check_in} = '0;
        write_byte_we = 8'hff;
        first_port_byte_we = 4'h0;
    end
    // Unused address bits carry junk; idle data is inverted
    task automatic op(input logic w, r, input waddr_type wa, ra, input data_type d, input check_type c,
                      input logic [1:0] inj);
        @(posedge clk);
        write_enable <= w;
        read_enable <= r;
        write_address <= {1'b1, wa, 6'h2a};
        read_address <= {1'b1, ra, 6'h15};
        write_data_in <= d;
        write_check_in <= c;
        {inject_double, inject_single} <= inj;
        @(posedge clk);
        write_enable <= 1'b0;
        read_enable <= 1'b0;
        {inject_double, inject_single} <= 2'b00;
        write_data_in <= ~d;
        #1;
    endtask : op
    // Byte-enable straps; a wrong strap must make the write vanish
    task automatic strap(input write_we_type bw, input first_we_type fw);
        @(posedge clk);
        write_byte_we <= bw;
        first_port_byte_we <= fw;
    endtask : strap
endmodule : fabric_model
`default_nettype wire

// ---- tb/sdp_ram_secded_ecc_tb.sv ----
// Purpose: Self-checking bench of the SECDED memory
// Assumes: fabric_model drives both ports
// Notes:   Flags compared as {single, double}
`timescale 1ns/1ns
`default_nettype none
module sdp_ram_secded_ecc_tb;
    import sdp_ecc_pkg::*;
    localparam data_type D0 = 64'h0123_4567_89ab_cdef;
    localparam data_type D1 = 64'hfedc_ba98_7654_3210;
    logic         clk, reset_n, encoder_enable, decoder_enable, output_register_enable;
    logic         write_first_mode, fifo_variant, write_enable, inject_single, inject_double, read_enable;
    logic         single_error_flag, double_error_flag;
    bus_addr_type write_address, read_address;
    write_we_type write_byte_we;
    first_we_type first_port_byte_we;
    data_type     write_data_in, read_data_out;
    check_type    write_check_in, read_check_out, check_bits_out;
    waddr_type    read_address_report;
    int           failures, checks;
    sdp_ram_secded_ecc uut (.*);
    fabric_model fab (.*);
    // ====
    // Reference code and comparisons
    function automatic check_type enc(input data_type d);
        logic [71:1] c;
        check_type   k;
        int          j;
        c = '0;
        k = '0;
        j = 0;
        for (int p = 1; p < 72; p++)
            if ((p & (p - 1)) != 0)
            begin
                c[p] = d[j];
                j++;
            end
        for (int p = 1; p < 72; p++)
            for (int b = 0; b < 7; b++)
                if (p[b])
                    k[b] ^= c[p];
        k[7] = ^{k[6:0], d};
        return k;
    endfunction : enc
    task automatic cmp_v(input logic [71:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_v
    task automatic cmp_f(input logic [1:0] got, exp);
        cmp_v({70'h0, got}, {70'h0, exp});
    endtask : cmp_f
    task automatic chk_rd(input data_type d, input check_type c, input logic [1:0] f, input waddr_type a);
        cmp_v(read_data_out, d);
        cmp_v(read_check_out, c);
        cmp_f({single_error_flag, double_error_flag}, f);
        cmp_v(read_address_report, a);
    endtask : chk_rd
    task automatic cfg(input logic [4:0] v);
        @(posedge clk);
        {encoder_enable, decoder_enable, output_register_enable, write_first_mode, fifo_variant} <= v;
    endtask : cfg
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // ====
    // Scenarios
    task automatic t_std;
        cfg(5'b11000);
        fab.op(1, 0, 9'h1a5, 0, D0, ~enc(D0), 0);
        cmp_v(check_bits_out, 8'h00);
        fab.op(1, 1, 9'h003, 9'h1a5, D1, 0, 0);
        chk_rd(D0, enc(D0), 2'b00, 9'h1a5);
        fab.op(0, 1, 0, 9'h003, 0, 0, 0);
        chk_rd(D1, enc(D1), 2'b00, 9'h003);
        repeat (3) @(posedge clk);
        cmp_v(read_data_out, D1);
        $display("test std done");
    endtask : t_std
    task automatic t_err;
        fab.op(1, 0, 9'h055, 0, D0, 0, 2'b01);
        fab.op(0, 1, 0, 9'h055, 0, 0, 0);
        chk_rd(D0, enc(D0), 2'b10, 9'h055);
        fab.op(0, 1, 0, 9'h055, 0, 0, 0);
        chk_rd(D0, enc(D0), 2'b10, 9'h055);
        fab.op(1, 0, 9'h056, 0, D1, 0, 2'b11);
        fab.op(0, 1, 0, 9'h056, 0, 0, 0);
        chk_rd(D1 ^ 64'h3, enc(D1), 2'b01, 9'h056);
        $display("test err done");
    endtask : t_err
    task automatic t_modes;
        cfg(5'b01000);
        fab.op(1, 0, 9'h100, 0, D1 ^ 64'h1, enc(D1), 0);
        fab.op(0, 1, 0, 9'h100, 0, 0, 0);
        chk_rd(D1, enc(D1), 2'b10, 9'h100);
        cfg(5'b10000);
        fab.op(1, 0, 9'h0f0, 0, D1, 0, 2'b01);
        cmp_v(check_bits_out, enc(D1));
        fab.op(0, 1, 0, 9'h0f0, 0, 0, 0);
        chk_rd(D1 ^ 64'h1, enc(D1), 2'b00, 9'h0f0);
        $display("test modes done");
    endtask : t_modes
    task automatic t_outreg;
        cfg(5'b11100);
        fab.op(0, 1, 0, 9'h1a5, 0, 0, 0);
        repeat (2) @(posedge clk);
        fab.op(0, 1, 0, 9'h003, 0, 0, 0);
        cmp_v(read_data_out, D0);
        @(posedge clk);
        #1;
        chk_rd(D1, enc(D1), 2'b00, 9'h003);
        $display("test outreg done");
    endtask : t_outreg
    task automatic t_strap;
        cfg(5'b11000);
        fab.strap(8'h7f, 4'h0);
        fab.op(1, 0, 9'h1a5, 0, D1, 0, 0);
        fab.strap(8'hff, 4'h1);
        fab.op(1, 0, 9'h1a5, 0, D1, 0, 0);
        fab.strap(8'hff, 4'h0);
        fab.op(0, 1, 0, 9'h1a5, 0, 0, 0);
        chk_rd(D0, enc(D0), 2'b00, 9'h1a5);
        $display("test strap done");
    endtask : t_strap
    task automatic t_collide;
        for (int m = 0; m < 2; m++)
        begin
            cfg({3'b110, m[0], 1'b0});
            fab.op(1, 0, 9'h0aa, 0, D0, 0, 0);
            fab.op(1, 1, 9'h0aa, 9'h0aa, D1, 0, 0);
            chk_rd(m ? D1 : D0, enc(m ? D1 : D0), 2'b00, 9'h0aa);
        end
        $display("test collide done");
    endtask : t_collide
    task automatic t_fifo;
        cfg(5'b00001);
        fab.op(1, 0, 9'h111, 0, D0, ~enc(D0), 2'b01);
        cmp_v(check_bits_out, 8'h00);
        fab.op(0, 1, 0, 9'h111, 0, 0, 0);
        chk_rd(D0, enc(D0), 2'b10, 9'h000);
        $display("test fifo done");
    endtask : t_fifo
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #20000;
        failures++;
        end_sim();
    end
    initial
    begin
        failures = 0;
        checks = 0;
        reset_n = 1'b0;
        {encoder_enable, decoder_enable, output_register_enable, write_first_mode, fifo_variant} = 5'b11000;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_std();
        t_err();
        t_modes();
        t_outreg();
        t_strap();
        t_collide();
        t_fifo();
        end_sim();
    end
endmodule : sdp_ram_secded_ecc_tb
`default_nettype wire
